/* File: pkg/ext_mem_port_pkg.sv */
// Shared constants and state types for the external data memory port.
package ext_mem_port_pkg;
    // Bus widths of the external data memory interface.
    localparam int ADDR_W = 15;
    localparam int DATA_W = 16;
    // Most significant address bit index.
    localparam int ADDR_MSB = 14;
    // Address shown on the bus from reset until the first access.
    localparam logic [ADDR_W-1:0] ADDR_RESET = 15'h0000;
    // Bank select encodings.
    localparam logic BANK_X = 1'b0;
    localparam logic BANK_Y = 1'b1;
    // Strobe width of one external access, in clock cycles.
    localparam logic [1:0] ACCESS_CYCLES = 2'h2;
    // Output enable level that means the pin is driven.
    localparam logic OE_DRIVE = 1'b0;
    localparam logic OE_FLOAT = 1'b1;

    // Port sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACCESS,
        ST_GRANT
    } port_state_e;

    // Complete state of the port.
    typedef struct packed {
        port_state_e       state;
        logic [1:0]        cnt;
        logic [ADDR_W-1:0] addr;
        logic              bank;
        logic              write;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic              rsp_valid;
        logic              grant_n;
        logic [2:0]        hold_sync;
        logic              hold_req;
    } port_s;
endpackage

/* File: src/ext_mem_port.sv */
// External data memory port with bus-hold handshake for a second master.
`timescale 1ns/1ps
// Notes on behaviour
// - Bank select low for X, high for Y.
// - Fifteen-bit address bus, bit fourteen highest.
// - Idle address bus keeps last accessed address.
// - Address reads zero until first access.
// - Data bus floats when idle or granted.
// - Grant output low when other master may use.
// - Bus-in-use output low during own access.
// - Granted: bank, address, strobes float.
module ext_mem_port (
    // Clock and synchronous active-low reset.
    input  wire logic                                   clk_sys,
    input  wire logic                                   rstn,
    // Core access request.
    input  wire logic                                   req_valid,
    output logic                                        req_ready,
    input  wire logic                                   req_write,
    input  wire logic                                   req_bank,
    input  wire logic [ext_mem_port_pkg::ADDR_W-1:0]    req_addr,
    input  wire logic [ext_mem_port_pkg::DATA_W-1:0]    req_wdata,
    // Core read answer.
    output logic                                        rsp_valid,
    output logic [ext_mem_port_pkg::DATA_W-1:0]         rsp_rdata,
    // External memory bank select.
    output logic                                        ext_bank_sel,
    output logic                                        ext_bank_sel_oe_n,
    // External address bus.
    output logic [ext_mem_port_pkg::ADDR_W-1:0]         ext_address_bus,
    output logic                                        ext_address_oe_n,
    // External data bus, split into its three signals.
    input  wire logic [ext_mem_port_pkg::DATA_W-1:0]    ext_data_bus_in,
    output logic [ext_mem_port_pkg::DATA_W-1:0]         ext_data_bus_out,
    output logic                                        ext_data_bus_oe_n,
    // External memory strobes and their shared enable.
    output logic                                        ext_read_strobe_n,
    output logic                                        ext_write_strobe_n,
    output logic                                        ext_strobe_oe_n,
    // Bus hold handshake and bus activity.
    input  wire logic                                   bus_hold_request_n,
    output logic                                        bus_hold_grant_n,
    output logic                                        bus_in_use_n
);

    // Current and next state of the whole port.
    ext_mem_port_pkg::port_s cur_ff;
    ext_mem_port_pkg::port_s nxt_cur;

    // Decoded conditions used by several outputs.
    logic in_access;    // Own access is driving the strobes.
    logic granted;      // Bus is handed to the other master.

    assign in_access = (cur_ff.state == ext_mem_port_pkg::ST_ACCESS);
    assign granted   = (cur_ff.state == ext_mem_port_pkg::ST_GRANT);

    // New requests are taken only in idle with no hold pending, so a
    // hold request cannot be starved by a busy core.
    assign req_ready = (cur_ff.state == ext_mem_port_pkg::ST_IDLE) && !cur_ff.hold_req;

    // Next-state logic for synchroniser, sequencer and latched access.
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.rsp_valid = 1'b0;
        // The request pin is asynchronous; only the second and third stages
        // are compared, so the first stage feeds nothing else.
        nxt_cur.hold_sync = {cur_ff.hold_sync[1:0], ~bus_hold_request_n};
        if (cur_ff.hold_sync[1] == cur_ff.hold_sync[2]) begin
            nxt_cur.hold_req = cur_ff.hold_sync[2];
        end
        case (cur_ff.state)
            ext_mem_port_pkg::ST_IDLE: begin
                if (cur_ff.hold_req) begin
                    nxt_cur.state   = ext_mem_port_pkg::ST_GRANT;
                    nxt_cur.grant_n = 1'b0;
                end else if (req_valid) begin
                    nxt_cur.state = ext_mem_port_pkg::ST_ACCESS;
                    nxt_cur.cnt   = ext_mem_port_pkg::ACCESS_CYCLES - 2'h1;
                    nxt_cur.addr  = req_addr;
                    nxt_cur.bank  = req_bank;
                    nxt_cur.write = req_write;
                    nxt_cur.wdata = req_wdata;
                end
            end
            ext_mem_port_pkg::ST_ACCESS: begin
                // The access always runs to its end; a hold waits for it.
                if (cur_ff.cnt == 2'h0) begin
                    nxt_cur.state     = ext_mem_port_pkg::ST_IDLE;
                    nxt_cur.rsp_valid = !cur_ff.write;
                    if (!cur_ff.write) begin
                        nxt_cur.rdata = ext_data_bus_in;
                    end
                end else begin
                    nxt_cur.cnt = cur_ff.cnt - 2'h1;
                end
            end
            ext_mem_port_pkg::ST_GRANT: begin
                if (!cur_ff.hold_req) begin
                    nxt_cur.state   = ext_mem_port_pkg::ST_IDLE;
                    nxt_cur.grant_n = 1'b1;
                end
            end
            default: begin
                nxt_cur.state   = ext_mem_port_pkg::ST_IDLE;
                nxt_cur.grant_n = 1'b1;
            end
        endcase
    end

    // State register with synchronous reset.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cur_ff.state     <= ext_mem_port_pkg::ST_IDLE;
            cur_ff.cnt       <= 2'h0;
            cur_ff.addr      <= ext_mem_port_pkg::ADDR_RESET;
            cur_ff.bank      <= ext_mem_port_pkg::BANK_X;
            cur_ff.write     <= 1'b0;
            cur_ff.wdata     <= 16'h0000;
            cur_ff.rdata     <= 16'h0000;
            cur_ff.rsp_valid <= 1'b0;
            cur_ff.grant_n   <= 1'b1;
            cur_ff.hold_sync <= 3'h0;
            cur_ff.hold_req  <= 1'b0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // Core answer comes straight from registers.
    assign rsp_valid = cur_ff.rsp_valid;
    assign rsp_rdata = cur_ff.rdata;

    assign ext_bank_sel = cur_ff.bank;
    assign ext_address_bus = cur_ff.addr;
    assign ext_bank_sel_oe_n = granted ? ext_mem_port_pkg::OE_FLOAT : ext_mem_port_pkg::OE_DRIVE;
    assign ext_address_oe_n  = granted ? ext_mem_port_pkg::OE_FLOAT : ext_mem_port_pkg::OE_DRIVE;
    assign ext_strobe_oe_n   = granted ? ext_mem_port_pkg::OE_FLOAT : ext_mem_port_pkg::OE_DRIVE;

    // data driven only on own writes
    assign ext_data_bus_out  = cur_ff.wdata;
    assign ext_data_bus_oe_n = (in_access && cur_ff.write) ? ext_mem_port_pkg::OE_DRIVE
                                                          : ext_mem_port_pkg::OE_FLOAT;

    assign ext_read_strobe_n  = !(in_access && !cur_ff.write);
    assign ext_write_strobe_n = !(in_access && cur_ff.write);

    assign bus_hold_grant_n = cur_ff.grant_n;
    assign bus_in_use_n = !in_access;

    // Checks on the pin behaviour, all on the single clock.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    // Helper: an access has started at some point since reset.
    logic seen_access_ff;
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            seen_access_ff <= 1'b0;
        end else if (in_access) begin
            seen_access_ff <= 1'b1;
        end
    end

    addr_reset_zero_a: assert property (
        !seen_access_ff && !in_access |-> ext_address_bus == 15'h0000)
        else $error("Address not zero before first access.");
    addr_hold_idle_a: assert property (
        !in_access && !$past(in_access) && !(req_valid && req_ready)
        |=> $stable(ext_address_bus))
        else $error("Address changed while idle.");
    addr_taken_a: assert property (
        req_valid && req_ready |=> ext_address_bus == $past(req_addr) && !bus_in_use_n)
        else $error("Address or access start wrong.");
    bank_select_a: assert property (
        req_valid && req_ready |=> ext_bank_sel == $past(req_bank))
        else $error("Bank select does not follow request.");
    strobe_excl_a: assert property (
        !(!ext_read_strobe_n && !ext_write_strobe_n))
        else $error("Read and write strobes both active.");
    strobe_width_a: assert property (
        req_valid && req_ready |=> !bus_in_use_n [*2] ##1 bus_in_use_n)
        else $error("Access strobe width wrong.");
    data_float_a: assert property (
        bus_in_use_n || !bus_hold_grant_n |-> ext_data_bus_oe_n)
        else $error("Data bus driven outside own access.");
    grant_float_a: assert property (
        !bus_hold_grant_n |-> ext_address_oe_n && ext_bank_sel_oe_n && ext_strobe_oe_n)
        else $error("Pins driven while bus granted.");
    grant_excl_a: assert property (
        !bus_hold_grant_n |-> bus_in_use_n)
        else $error("Grant overlaps own access.");
    grant_latency_a: assert property (
        !bus_hold_request_n [*6] |-> ##[0:4] !bus_hold_grant_n)
        else $error("Hold request not granted in time.");
    grant_release_a: assert property (
        !bus_hold_grant_n ##1 bus_hold_request_n [*4] |-> ##[0:2] bus_hold_grant_n)
        else $error("Grant not released after request ends.");
    // During a read the memory owns the data wires, so the port must let go.
    data_read_float_a: assert property (
        !ext_read_strobe_n |-> ext_data_bus_oe_n)
        else $error("Data bus driven during a read.");
    // Write data must be on the wires for as long as the write strobe is low.
    data_write_drive_a: assert property (
        !ext_write_strobe_n |-> !ext_data_bus_oe_n)
        else $error("Data bus floating during a write.");

    read_cover_c: cover property (req_valid && req_ready && !req_write ##3 rsp_valid);
    write_cover_c: cover property (!ext_write_strobe_n);
    grant_cover_c: cover property ($fell(bus_hold_grant_n));
    hold_wait_c: cover property (!bus_in_use_n && !bus_hold_request_n ##[1:6] !bus_hold_grant_n);

endmodule

/* File: testbench/ext_data_memory_port_hold_tb.sv */
// Self-checking bench for the external data memory port.
`timescale 1ns/1ps
module ext_data_memory_port_hold_tb;
    logic clk_sys = 1'b0, rstn = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    logic req_bank = 1'b0, bus_hold_request_n = 1'b1;
    logic [14:0] req_addr = 15'h0000;
    logic [15:0] req_wdata = 16'h0000, din, dout, rsp_rdata;
    logic req_ready, rsp_valid, bsel, bsel_oe_n, a_oe_n, d_oe_n, rd_n, wr_n, s_oe_n;
    logic bus_hold_grant_n, bus_in_use_n;
    logic [14:0] abus;
    logic [15:0] exp [0:31]; // Expected memory contents.
    int num_errors = 0, comparisons = 0, i;
    // Free-running 100 MHz clock.
    always #5 clk_sys = ~clk_sys;
    ext_mem_port ext_mem_port_inst (.clk_sys(clk_sys), .rstn(rstn), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_bank(req_bank),
        .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .ext_bank_sel(bsel), .ext_bank_sel_oe_n(bsel_oe_n),
        .ext_address_bus(abus), .ext_address_oe_n(a_oe_n), .ext_data_bus_in(din),
        .ext_data_bus_out(dout), .ext_data_bus_oe_n(d_oe_n), .ext_read_strobe_n(rd_n),
        .ext_write_strobe_n(wr_n), .ext_strobe_oe_n(s_oe_n),
        .bus_hold_request_n(bus_hold_request_n), .bus_hold_grant_n(bus_hold_grant_n),
        .bus_in_use_n(bus_in_use_n));
    ext_mem_model ext_mem_model_inst (.clk_sys(clk_sys), .addr(abus), .bank(bsel),
        .rd_n(rd_n), .wr_n(wr_n), .strobe_oe_n(s_oe_n), .dout(dout), .dout_oe_n(d_oe_n),
        .din(din));
    // Compares with case equality so an unknown never matches.
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic conclude();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // While granted away, the port must be quiet and refuse requests.
    always @(negedge clk_sys) begin
        if (bus_hold_grant_n === 1'b0) begin
            chk(bus_in_use_n, 1'b1);
            chk({bsel_oe_n, a_oe_n, s_oe_n, d_oe_n, req_ready}, 5'h1E);
        end
    end
    // One core access, judged cycle by cycle, then the idle address.
    task automatic access(input logic w, input logic b, input logic [14:0] a,
                          input logic [15:0] d);
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_write <= w;
        req_bank <= b;
        req_addr <= a;
        req_wdata <= d;
        @(negedge clk_sys);
        for (i = 0; i < 20 && req_ready !== 1'b1; i++) @(negedge clk_sys);
        @(posedge clk_sys);
        req_valid <= 1'b0;
        repeat (2) begin
            @(negedge clk_sys);
            chk({rd_n, wr_n, bus_in_use_n, d_oe_n}, {w, !w, 1'b0, !w});
            chk({bsel, abus}, {b, a});
        end
        @(negedge clk_sys);
        chk({rd_n, wr_n, bus_in_use_n, d_oe_n}, 4'hF);
        // A grant can come one edge later at the earliest, so the address is still driven.
        chk(a_oe_n, 1'b0);
        if (!w) chk({rsp_valid, rsp_rdata}, {1'b1, exp[{b, a[3:0]}]});
        if (w) exp[{b, a[3:0]}] = d;
        repeat (2) @(negedge clk_sys);
        // The held address stays put even if the bus has been granted away meanwhile.
        chk(abus, a);
    endtask
    // Hold handshake, idle or raised just before an access is taken.
    task automatic hold(input logic mid);
        @(posedge clk_sys);
        // Other master claims the bus.
        bus_hold_request_n <= 1'b0;
        if (mid) access(1'b1, 1'b1, 15'h7FFF, 16'hA5C3);
        for (i = 0; i < 12 && bus_hold_grant_n !== 1'b0; i++) @(negedge clk_sys);
        // Three sync stages, the agreement flop and the grant flop: five edges, i counts one more.
        if (!mid) chk(i, 6);
        chk(bus_hold_grant_n, 1'b0);
        repeat (4) @(negedge clk_sys);
        @(posedge clk_sys);
        bus_hold_request_n <= 1'b1;
        for (i = 0; i < 12 && bus_hold_grant_n !== 1'b1; i++) @(negedge clk_sys);
        chk(bus_hold_grant_n, 1'b1);
        @(negedge clk_sys);
        chk({bsel_oe_n, a_oe_n, s_oe_n}, 3'h0);
    endtask
    // Watchdog: the whole run needs under a hundred cycles.
    initial begin
        #20000;
        num_errors++;
        conclude();
    end
    // Main sequence.
    initial begin
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        @(negedge clk_sys);
        chk({abus, bsel, rd_n, wr_n, d_oe_n, bus_hold_grant_n}, 20'h0000F);
        access(1'b1, 1'b0, 15'h0005, 16'h1234);
        access(1'b1, 1'b1, 15'h4005, 16'hFEDC);
        access(1'b0, 1'b0, 15'h0005, 16'h0000);
        access(1'b0, 1'b1, 15'h4005, 16'h0000);
        hold(1'b0);
        hold(1'b1);
        access(1'b0, 1'b1, 15'h7FFF, 16'h0000);
        conclude();
    end
endmodule

/* File: testbench/ext_mem_model.sv */
// Behavioural external data memory that answers the port's strobes.
`timescale 1ns/1ps
module ext_mem_model (
    // Clock.
    input  wire logic        clk_sys,
    // Pins of the port.
    input  wire logic [14:0] addr,
    input  wire logic        bank,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic        strobe_oe_n,
    input  wire logic [15:0] dout,
    input  wire logic        dout_oe_n,
    // Level seen on the data wire.
    output logic      [15:0] din
);
    logic [15:0] mem [0:31]; // Only low address bits decode, to stay small.
    logic [15:0] last_ff;    // Last level seen on the wire.
    // Writes land on each edge while the write strobe is low.
    always @(posedge clk_sys) begin
        last_ff <= din;
        if (strobe_oe_n == 1'b0 && wr_n == 1'b0) begin
            mem[{bank, addr[3:0]}] <= dout;
        end
    end
    // A floating wire toggles each cycle, so stale data never passes.
    always_comb begin
        if (dout_oe_n == 1'b0)
            din = dout;
        else if (strobe_oe_n == 1'b0 && rd_n == 1'b0)
            din = mem[{bank, addr[3:0]}];
        else
            din = ~last_ff;
    end
endmodule
